//--- logic/pcrt_defs.svh
// Register offsets, field positions, reset values and timing for the trip block
`ifndef PCRT_DEFS_SVH
`define PCRT_DEFS_SVH

// ==========================================================
// Register byte offsets
`define PCRT_OFF_FILT 12'h000
`define PCRT_OFF_RAMP 12'h004
`define PCRT_OFF_STEP 12'h008
`define PCRT_OFF_END 12'h00c
`define PCRT_OFF_EADC 12'h010
`define PCRT_OFF_APCM 12'h014
`define PCRT_OFF_LIM0 12'h018
`define PCRT_OFF_TRIG 12'h028
`define PCRT_OFF_STAT 12'h02c
`define PCRT_WORD 12'h004

// ==========================================================
// Field positions
`define PCRT_B_FSEL 0
`define PCRT_B_RAMP_EN 0
`define PCRT_B_START_SEL 1
`define PCRT_B_END_EN 2
`define PCRT_B_D2S 0
`define PCRT_F_MODE 6:4
`define PCRT_F_FE 1:0
`define PCRT_B_PCM_EN 4
`define PCRT_B_LIM_EN 0
`define PCRT_F_FRAME 3:0
`define PCRT_F_PIN 7:4
`define PCRT_F_LEVEL 13:0
`define PCRT_F_ST 17:16
`define PCRT_B_TRIP 20

// ==========================================================
// Values
`define PCRT_MODE_PCM 3'h5
`define PCRT_FE_NONE 2'h3
`define PCRT_RST_BIT 1'b0
`define PCRT_RST_LEVEL 14'h0000
`define PCRT_RST_MODE 3'h0
`define PCRT_RST_FE 2'h0
`define PCRT_RST_NIB 4'h0
`define PCRT_LEVEL_MAX 14'h3fff

// ==========================================================
// Timing: clock period and ramp step time in ns
`define PCRT_CLK_NS 6'd20
`define PCRT_STEP_NS 6'd32

`endif

//--- logic/pcrt_pkg.sv
// Types shared by the peak-current trip block
package pcrt_pkg;
    typedef logic [13:0] pcrt_level_t;
    typedef enum logic [1:0]
    {
        PCRT_IDLE = 2'b00,
        PCRT_RUN = 2'b01,
        PCRT_HOLD = 2'b10
    } pcrt_ramp_st_t;
endpackage

//--- logic/pcrt_step_tick.sv
// Ramp step pacing: one tick per 32 ns on average from a 20 ns clock
`timescale 1ns/100ps
`include "pcrt_defs.svh"
module pcrt_step_tick
    import pcrt_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_run,
    output logic o_tick
);
    logic [5:0] acc_reg;
    logic [5:0] acc_next;

    // ==========================================================
    // Phase accumulator
    // Step time is not a whole number of clocks, so ticks fall
    // 1 or 2 cycles apart and average exactly one step time
    assign acc_next = acc_reg + `PCRT_CLK_NS;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            acc_reg <= 6'h00;
            o_tick <= 1'b0;
        end
        else if (!i_run)
        begin
            acc_reg <= 6'h00;
            o_tick <= 1'b0;
        end
        else if (acc_next >= `PCRT_STEP_NS)
        begin
            acc_reg <= acc_next - `PCRT_STEP_NS;
            o_tick <= 1'b1;
        end
        else
        begin
            acc_reg <= acc_next;
            o_tick <= 1'b0;
        end
    end

    // ==========================================================
    // Checks
    // Two ticks in a row are legal, three would outrun the step time
    property p_step_gap;
        @(posedge i_clk) disable iff (!i_rst_n)
        o_tick ##1 o_tick |=> !o_tick;
    endproperty
    a_step_gap: assert property (p_step_gap) else $error("ticks too dense");

    property p_step_due;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_run [*4] |-> (o_tick || $past(o_tick) || $past(o_tick, 2));
    endproperty
    a_step_due: assert property (p_step_due) else $error("ramp step overdue");
endmodule

//--- logic/pcrt_top.sv
// Peak-current ramp and trip routing with its APB register file
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/100ps
`include "pcrt_defs.svh"
module pcrt_top
    import pcrt_pkg::*;
(
    input wire logic I_CLOCK,
    input wire logic I_RST_N,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire logic [13:0] I_FILTER0,
    input wire logic [13:0] I_FILTER1,
    input wire logic [13:0] I_FE0_CURRENT,
    input wire logic [13:0] I_FE1_CURRENT,
    input wire logic [13:0] I_FE2_CURRENT,
    input wire logic [3:0] I_FRAME_START,
    input wire logic [3:0] I_PWM_PIN,
    output logic O_TRIP,
    output logic [3:0] O_CYCLE_LIMIT_INPUT,
    output logic [13:0] O_RAMP_LEVEL
);
    // ==========================================================
    // Declarations
    logic filter_sel_reg;
    logic ramp_en_reg;
    logic start_sel_reg;
    logic end_en_reg;
    pcrt_level_t slope_increment_reg;
    pcrt_level_t slope_final_value_reg;
    logic diff_to_single_comparator_on_reg;
    logic [2:0] front_end_op_select_reg;
    logic [1:0] peak_source_front_end_choice_reg;
    logic pcm_en_reg;
    logic [3:0] lim_en_reg;
    logic [3:0] frame_trig_en_reg;
    logic [3:0] pin_trig_en_reg;
    logic [3:0] pin_s1_reg;
    logic [3:0] pin_s2_reg;
    logic [3:0] pin_d_reg;
    pcrt_ramp_st_t st_reg;
    pcrt_ramp_st_t st_next;
    pcrt_level_t ramp_reg;
    pcrt_level_t ramp_next;
    pcrt_level_t start_val;
    pcrt_level_t target;
    pcrt_level_t cur_sel;
    logic [14:0] sum_up;
    logic [14:0] diff_dn;
    logic trig;
    logic tick;
    logic trip_active;
    logic trip_next;
    logic bus_req;
    logic bus_wr;
    logic [31:0] rd_data;

    // ==========================================================
    // Decode helpers
    function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] off);
        reg_hit = (a == off);
    endfunction

    function automatic logic in_map(input logic [11:0] a);
        in_map = (a[1:0] == 2'b00) && (a <= `PCRT_OFF_STAT);
    endfunction

    // ==========================================================
    // APB slave: one wait state, answer registered
    assign bus_req = I_PSEL && I_PENABLE && !O_PREADY;
    assign bus_wr = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && in_map(I_PADDR);

    always_ff @(posedge I_CLOCK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            O_PREADY <= 1'b0;
            O_PRDATA <= 32'h00000000;
            O_PSLVERR <= 1'b0;
        end
        else
        begin
            O_PREADY <= bus_req;
            O_PRDATA <= (bus_req && !I_PWRITE) ? rd_data : 32'h00000000;
            O_PSLVERR <= bus_req && !in_map(I_PADDR);
        end
    end

    // Control registers, written at the completing edge only
    always_ff @(posedge I_CLOCK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            filter_sel_reg <= `PCRT_RST_BIT;
            ramp_en_reg <= `PCRT_RST_BIT;
            start_sel_reg <= `PCRT_RST_BIT;
            end_en_reg <= `PCRT_RST_BIT;
            slope_increment_reg <= `PCRT_RST_LEVEL;
            slope_final_value_reg <= `PCRT_RST_LEVEL;
            diff_to_single_comparator_on_reg <= `PCRT_RST_BIT;
            front_end_op_select_reg <= `PCRT_RST_MODE;
            peak_source_front_end_choice_reg <= `PCRT_RST_FE;
            pcm_en_reg <= `PCRT_RST_BIT;
            frame_trig_en_reg <= `PCRT_RST_NIB;
            pin_trig_en_reg <= `PCRT_RST_NIB;
        end
        else if (bus_wr)
        begin
            if (reg_hit(I_PADDR, `PCRT_OFF_FILT))
                filter_sel_reg <= I_PWDATA[`PCRT_B_FSEL];
            if (reg_hit(I_PADDR, `PCRT_OFF_RAMP))
            begin
                ramp_en_reg <= I_PWDATA[`PCRT_B_RAMP_EN];
                start_sel_reg <= I_PWDATA[`PCRT_B_START_SEL];
                end_en_reg <= I_PWDATA[`PCRT_B_END_EN];
            end
            if (reg_hit(I_PADDR, `PCRT_OFF_STEP))
                slope_increment_reg <= I_PWDATA[`PCRT_F_LEVEL];
            if (reg_hit(I_PADDR, `PCRT_OFF_END))
                slope_final_value_reg <= I_PWDATA[`PCRT_F_LEVEL];
            if (reg_hit(I_PADDR, `PCRT_OFF_EADC))
            begin
                diff_to_single_comparator_on_reg <= I_PWDATA[`PCRT_B_D2S];
                front_end_op_select_reg <= I_PWDATA[`PCRT_F_MODE];
            end
            if (reg_hit(I_PADDR, `PCRT_OFF_APCM))
            begin
                peak_source_front_end_choice_reg <= I_PWDATA[`PCRT_F_FE];
                pcm_en_reg <= I_PWDATA[`PCRT_B_PCM_EN];
            end
            // frame sync and pin trigger enables
            if (reg_hit(I_PADDR, `PCRT_OFF_TRIG))
            begin
                frame_trig_en_reg <= I_PWDATA[`PCRT_F_FRAME];
                pin_trig_en_reg <= I_PWDATA[`PCRT_F_PIN];
            end
        end
    end

    // ==========================================================
    // Per-modulator limit routing words
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_lim
            always_ff @(posedge I_CLOCK or negedge I_RST_N)
            begin
                if (!I_RST_N)
                    lim_en_reg[gi] <= `PCRT_RST_BIT;
                else if (bus_wr && reg_hit(I_PADDR, `PCRT_OFF_LIM0 + 12'(gi) * `PCRT_WORD))
                    lim_en_reg[gi] <= I_PWDATA[`PCRT_B_LIM_EN];
            end
        end
    endgenerate

    // Read mux; reserved bits read zero
    always_comb
    begin
        rd_data = 32'h00000000;
        if (reg_hit(I_PADDR, `PCRT_OFF_FILT))
            rd_data[`PCRT_B_FSEL] = filter_sel_reg;
        if (reg_hit(I_PADDR, `PCRT_OFF_RAMP))
            rd_data[2:0] = {end_en_reg, start_sel_reg, ramp_en_reg};
        if (reg_hit(I_PADDR, `PCRT_OFF_STEP))
            rd_data[`PCRT_F_LEVEL] = slope_increment_reg;
        if (reg_hit(I_PADDR, `PCRT_OFF_END))
            rd_data[`PCRT_F_LEVEL] = slope_final_value_reg;
        if (reg_hit(I_PADDR, `PCRT_OFF_EADC))
        begin
            rd_data[`PCRT_B_D2S] = diff_to_single_comparator_on_reg;
            rd_data[`PCRT_F_MODE] = front_end_op_select_reg;
        end
        if (reg_hit(I_PADDR, `PCRT_OFF_APCM))
        begin
            rd_data[`PCRT_F_FE] = peak_source_front_end_choice_reg;
            rd_data[`PCRT_B_PCM_EN] = pcm_en_reg;
        end
        for (int i = 0; i < 4; i++)
            if (reg_hit(I_PADDR, `PCRT_OFF_LIM0 + 12'(i) * `PCRT_WORD))
                rd_data[`PCRT_B_LIM_EN] = lim_en_reg[i];
        if (reg_hit(I_PADDR, `PCRT_OFF_TRIG))
            rd_data[7:0] = {pin_trig_en_reg, frame_trig_en_reg};
        if (reg_hit(I_PADDR, `PCRT_OFF_STAT))
        begin
            rd_data[`PCRT_F_LEVEL] = ramp_reg;
            rd_data[`PCRT_F_ST] = st_reg;
            rd_data[`PCRT_B_TRIP] = O_TRIP;
        end
    end

    // ==========================================================
    // Ramp trigger
    // Pins are asynchronous: two flops, then an edge detector on
    // the second flop only
    always_ff @(posedge I_CLOCK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            pin_s1_reg <= `PCRT_RST_NIB;
            pin_s2_reg <= `PCRT_RST_NIB;
            pin_d_reg <= `PCRT_RST_NIB;
        end
        else
        begin
            pin_s1_reg <= I_PWM_PIN;
            pin_s2_reg <= pin_s1_reg;
            pin_d_reg <= pin_s2_reg;
        end
    end

    // frame-start trigger and pin rising edge trigger
    assign trig = |((I_FRAME_START & frame_trig_en_reg)
                  | (pin_s2_reg & ~pin_d_reg & pin_trig_en_reg));

    pcrt_step_tick u_step
    (
        .i_clk(I_CLOCK),
        .i_rst_n(I_RST_N),
        .i_run(st_reg == PCRT_RUN && !trig),
        .o_tick(tick)
    );

    // ==========================================================
    // Ramp level
    // filter pick or zero level as ramp start
    // zero start unless the filter source is chosen
    assign start_val = !start_sel_reg ? `PCRT_RST_LEVEL
                     : (filter_sel_reg ? I_FILTER1 : I_FILTER0);
    assign target = end_en_reg ? slope_final_value_reg : `PCRT_LEVEL_MAX;
    assign sum_up = {1'b0, ramp_reg} + {1'b0, slope_increment_reg};
    assign diff_dn = {1'b0, ramp_reg} - {1'b0, slope_increment_reg};

    // reload, step toward end, hold there
    always_comb
    begin
        st_next = st_reg;
        ramp_next = ramp_reg;
        case (st_reg)
            PCRT_IDLE:
            begin
                if (trig)
                begin
                    st_next = PCRT_RUN;
                    ramp_next = start_val;
                end
            end
            PCRT_RUN, PCRT_HOLD:
            begin
                // A held ramp moves on again if the end value changes
                st_next = PCRT_RUN;
                if (trig)
                begin
                    st_next = PCRT_RUN;
                    ramp_next = start_val;
                end
                else if (ramp_reg == target)
                    st_next = PCRT_HOLD;
                // one step per tick, step size
                else if (tick && ramp_reg < target)
                    ramp_next = (sum_up >= {1'b0, target}) ? target : sum_up[13:0];
                else if (tick)
                    ramp_next = (diff_dn[14] || diff_dn[13:0] <= target)
                              ? target : diff_dn[13:0];
            end
            default:
            begin
                st_next = PCRT_IDLE;
                ramp_next = `PCRT_RST_LEVEL;
            end
        endcase
        if (!ramp_en_reg)
        begin
            st_next = PCRT_IDLE;
            ramp_next = `PCRT_RST_LEVEL;
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            st_reg <= PCRT_IDLE;
            ramp_reg <= `PCRT_RST_LEVEL;
        end
        else
        begin
            st_reg <= st_next;
            ramp_reg <= ramp_next;
        end
    end

    // ==========================================================
    // Peak comparator and trip routing
    // single comparator, any front end feeds it
    always_comb
    begin
        case (peak_source_front_end_choice_reg)
            2'h0: cur_sel = I_FE0_CURRENT;
            2'h1: cur_sel = I_FE1_CURRENT;
            2'h2: cur_sel = I_FE2_CURRENT;
            default: cur_sel = `PCRT_LEVEL_MAX;
        endcase
    end

    // comparator path, mode 5, enable gate
    assign trip_active = pcm_en_reg && diff_to_single_comparator_on_reg
                      && front_end_op_select_reg == `PCRT_MODE_PCM
                      && peak_source_front_end_choice_reg != `PCRT_FE_NONE
                      && st_reg != PCRT_IDLE;
    assign trip_next = trip_active && (ramp_reg > cur_sel);

    // per-modulator limit, low when no trip
    always_ff @(posedge I_CLOCK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            O_TRIP <= 1'b0;
            O_CYCLE_LIMIT_INPUT <= 4'h0;
            O_RAMP_LEVEL <= `PCRT_RST_LEVEL;
        end
        else
        begin
            O_TRIP <= trip_next;
            O_CYCLE_LIMIT_INPUT <= {4{trip_next}} & lim_en_reg;
            O_RAMP_LEVEL <= ramp_next;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_N);

    property p_trip_cmp;
        trip_active && ramp_reg > cur_sel |=> O_TRIP;
    endproperty
    a_trip_cmp: assert property (p_trip_cmp) else $error("trip missed");

    property p_reload;
        trig && ramp_en_reg |=> ramp_reg == $past(start_val) && st_reg == PCRT_RUN;
    endproperty
    a_reload: assert property (p_reload) else $error("ramp not reloaded");

    property p_filt1;
        trig && ramp_en_reg && start_sel_reg && filter_sel_reg |=> ramp_reg == $past(I_FILTER1);
    endproperty
    a_filt1: assert property (p_filt1) else $error("filter 1 not used");

    property p_ramp_off;
        !ramp_en_reg |=> st_reg == PCRT_IDLE && ramp_reg == `PCRT_RST_LEVEL ##1 !O_TRIP;
    endproperty
    a_ramp_off: assert property (p_ramp_off) else $error("ramp runs disabled");

    property p_end_hold;
        st_reg == PCRT_HOLD |-> ramp_reg == $past(target);
    endproperty
    a_end_hold: assert property (p_end_hold) else $error("hold off end value");

    property p_mode;
        front_end_op_select_reg != `PCRT_MODE_PCM |=> !O_TRIP;
    endproperty
    a_mode: assert property (p_mode) else $error("trip outside mode 5");

    property p_gate;
        !pcm_en_reg || !diff_to_single_comparator_on_reg |=> O_TRIP == 1'b0;
    endproperty
    a_gate: assert property (p_gate) else $error("trip not gated");

    property p_route;
        O_CYCLE_LIMIT_INPUT != 4'h0 |-> O_TRIP;
    endproperty
    a_route: assert property (p_route) else $error("limit without trip");

    property p_apb;
        I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY ##1 !O_PREADY;
    endproperty
    a_apb: assert property (p_apb) else $error("apb answer late");

    c_trip: cover property (trig ##[1:40] $rose(O_TRIP));
    c_hold: cover property (st_reg == PCRT_RUN ##1 st_reg == PCRT_HOLD);
    c_pin: cover property (|(pin_s2_reg & ~pin_d_reg & pin_trig_en_reg));
    c_err: cover property (O_PSLVERR);
endmodule

//--- test/pcrt_far_model.sv
// Far-side stand-in: four staggered modulators and the sensed front-end currents
`timescale 1ns/100ps
module pcrt_far_model
#(
    parameter int PERIOD = 64
)
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_run,
    input wire logic [13:0] i_cur0,
    input wire logic [13:0] i_cur1,
    input wire logic [13:0] i_cur2,
    output logic [3:0] o_frame_start,
    output logic [3:0] o_pwm_pin,
    output logic [13:0] o_fe0,
    output logic [13:0] o_fe1,
    output logic [13:0] o_fe2
);
    logic [7:0] cnt_reg;

    // ==========================================================
    // Period counter, frozen while the modulators are stopped
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            cnt_reg <= 8'h00;
        else if (i_run)
            cnt_reg <= (cnt_reg == 8'(PERIOD - 1)) ? 8'h00 : cnt_reg + 8'h01;
    end

    // Frame pulse and pin high phase, a quarter period apart per modulator
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_frame_start <= 4'h0;
            o_pwm_pin <= 4'h0;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                o_frame_start[i] <= i_run && (cnt_reg == 8'(i * PERIOD / 4));
                o_pwm_pin[i] <= i_run && (cnt_reg >= 8'(i * PERIOD / 4))
                    && (cnt_reg < 8'(i * PERIOD / 4 + PERIOD / 2));
            end
        end
    end

    // Sensed currents held steady; the bench sets the levels
    assign o_fe0 = i_cur0;
    assign o_fe1 = i_cur1;
    assign o_fe2 = i_cur2;
endmodule

//--- test/pcrt_top_tb.sv
// Self-checking bench for the peak-current ramp and trip block
`timescale 1ns/100ps
`include "pcrt_defs.svh"
module pcrt_top_tb;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, trip, run, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [13:0] filt0, filt1, ramp, cur0, cur1, cur2, fe0, fe1, fe2, base;
    logic [3:0] frame, pin, lim, lim_mask;
    int n_fail, comparisons, h;

    pcrt_top u_pcrt_top (.I_CLOCK(clk), .I_RST_N(rst_n), .I_PSEL(psel),
        .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_FILTER0(filt0),
        .I_FILTER1(filt1), .I_FE0_CURRENT(fe0), .I_FE1_CURRENT(fe1),
        .I_FE2_CURRENT(fe2), .I_FRAME_START(frame), .I_PWM_PIN(pin), .O_TRIP(trip),
        .O_CYCLE_LIMIT_INPUT(lim), .O_RAMP_LEVEL(ramp));
    pcrt_far_model u_pcrt_far_model (.i_clk(clk), .i_rst_n(rst_n), .i_run(run),
        .i_cur0(cur0), .i_cur1(cur1), .i_cur2(cur2), .o_frame_start(frame),
        .o_pwm_pin(pin), .o_fe0(fe0), .o_fe1(fe1), .o_fe2(fe2));

    // ==========================================================
    // Shared tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // One APB transfer; the request holds until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Read just after the edge: the values the master sampled there
        for (k = 0; k < 20; k++)
        begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        if (k == 20)
        begin
            n_fail++;
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Lands one cycle after a modulator 0 frame start, on the reload
    task automatic wait_frame();
        int k;
        for (k = 0; k < 200 && frame[0] !== 1'b1; k++)
            @(negedge clk);
        if (k == 200)
        begin
            n_fail++;
            final_report();
        end
        @(negedge clk);
    endtask

    // Counts trip cycles; each must follow a ramp above the current
    task automatic watch(input int n, input logic [13:0] c, output int hits);
        logic [13:0] last;
        hits = 0;
        last = ramp;
        repeat (n)
        begin
            @(negedge clk);
            if (trip === 1'b1)
            begin
                hits++;
                chk("trip cause", 32'h1, {31'h0, last > c});
                chk("limit route", {28'h0, lim_mask}, {28'h0, lim});
            end
            else
                chk("limit idle", 32'h0, {28'h0, lim});
            last = ramp;
        end
    endtask

    task automatic gate(input logic [11:0] a, input logic [31:0] bad, good);
        apb(1'b1, a, bad);
        // Trip is registered: the old gate still shows for one cycle
        @(negedge clk);
        watch(70, cur2, h);
        chk("gated trips", 32'h0, h);
        apb(1'b1, a, good);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        for (int a = 0; a <= 'h2c; a += 4)
        begin
            apb(1'b0, 12'(a), 32'h0);
            chk("reset value", 32'h0, rd);
            chk("reset err", 32'h0, {31'h0, err});
        end
        apb(1'b0, 12'h030, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        apb(1'b0, 12'h002, 32'h0);
        chk("misaligned err", 32'h1, {31'h0, err});
    endtask

    task automatic t_setup();
        apb(1'b1, `PCRT_OFF_RAMP, 32'h3);
        apb(1'b1, `PCRT_OFF_STEP, 32'h00a);
        apb(1'b0, `PCRT_OFF_STEP, 32'h0);
        chk("step readback", 32'h00a, rd);
        apb(1'b1, `PCRT_OFF_EADC, 32'h51);
        apb(1'b1, `PCRT_OFF_APCM, 32'h12);
        for (int i = 0; i < 4; i++)
            apb(1'b1, `PCRT_OFF_LIM0 + 12'(4 * i), {31'h0, lim_mask[i]});
        apb(1'b1, `PCRT_OFF_TRIG, 32'h1);
    endtask

    task automatic t_ramp();
        wait_frame();
        chk("reload filter0", 32'h064, {18'h0, ramp});
        repeat (4) @(negedge clk);
        base = ramp;
        repeat (16) @(negedge clk);
        chk("ten steps", 32'h064, {18'h0, ramp - base});
        watch(140, cur2, h);
        chk("trip seen", 32'h1, {31'h0, h > 0});
        // Constant-current handover by software
        apb(1'b1, `PCRT_OFF_FILT, 32'h1);
        wait_frame();
        chk("reload filter1", 32'h0c8, {18'h0, ramp});
        apb(1'b1, `PCRT_OFF_FILT, 32'h0);
        apb(1'b1, `PCRT_OFF_RAMP, 32'h1);
        wait_frame();
        chk("start zero", 32'h0, {18'h0, ramp});
        apb(1'b1, `PCRT_OFF_END, 32'h082);
        apb(1'b1, `PCRT_OFF_RAMP, 32'h7);
        wait_frame();
        repeat (30) @(negedge clk);
        chk("end hold", 32'h082, {18'h0, ramp});
        apb(1'b1, `PCRT_OFF_RAMP, 32'h3);
    endtask

    task automatic t_gates();
        gate(`PCRT_OFF_EADC, 32'h50, 32'h51);
        gate(`PCRT_OFF_EADC, 32'h41, 32'h51);
        gate(`PCRT_OFF_APCM, 32'h02, 32'h12);
        gate(`PCRT_OFF_RAMP, 32'h02, 32'h03);
        for (int k = 0; k < 3; k++)
        begin
            apb(1'b1, `PCRT_OFF_APCM, 32'h10 | k);
            @(negedge clk);
            watch(90, k == 0 ? cur0 : k == 1 ? cur1 : cur2, h);
            chk("source trips", {31'h0, k != 1}, {31'h0, h > 0});
        end
    endtask

    task automatic t_pin();
        apb(1'b1, `PCRT_OFF_TRIG, 32'h0);
        apb(1'b1, `PCRT_OFF_RAMP, 32'h2);
        apb(1'b1, `PCRT_OFF_RAMP, 32'h3);
        h = 0;
        repeat (80)
        begin
            @(negedge clk);
            h += (ramp !== 14'h0000);
        end
        chk("no trigger idle", 32'h0, h);
        apb(1'b1, `PCRT_OFF_TRIG, 32'h20);
        for (h = 0; h < 100 && ramp !== 14'h0064; h++)
            @(negedge clk);
        chk("pin trigger", 32'h1, {31'h0, h < 100});
    endtask

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial
    begin
        {rst_n, psel, penable, pwrite, run} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        {filt0, filt1} = {14'h064, 14'h0c8};
        {cur0, cur1, cur2} = {14'h096, 14'h2328, 14'h12c};
        lim_mask = 4'hb;
        n_fail = 0;
        comparisons = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk("reset outputs", 32'h0, {13'h0, ramp, trip, lim});
        t_reset();
        t_setup();
        run <= 1'b1;
        t_ramp();
        t_gates();
        t_pin();
        final_report();
    end
endmodule
